/* File: rtl/epiu_pkg.sv */
package epiu_pkg;

   // register indices on the plain register port
   localparam logic [2:0] REG_SENSE   = 3'h0;
   localparam logic [2:0] REG_ENABLE  = 3'h1;
   localparam logic [2:0] REG_FLAGS   = 3'h2;
   localparam logic [2:0] REG_MASK_LO = 3'h3;
   localparam logic [2:0] REG_MASK_HI = 3'h4;

   // bit positions in enable and flag registers
   localparam int BIT_DED = 0;
   localparam int BIT_LO  = 6;
   localparam int BIT_HI  = 7;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;

   // sense select encodings
   localparam logic [1:0] SENSE_LOW  = 2'h0;
   localparam logic [1:0] SENSE_ANY  = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_RISE = 2'h3;

   // request and acknowledge toward the cpu, one bit per vector
   typedef struct packed {
      logic hi;
      logic lo;
      logic ded;
   } epiu_vec_t;

endpackage

/* File: rtl/epiu_top.sv */
// Notes on behaviour
// - sense field 00 low level, 01 any change, 10 falling, 11 rising.
// - pin is registered before edge detect; pulses over a clock are caught.
// - dedicated request only with global bit and its enable bit set.
// - enable bit 7 enables the upper pin-change group on its vector.
// - enable bit 6 enables the lower pin-change group on its vector.
// - enable bit 0 enables dedicated pin; works even when pin is an output.
// - flag bit 7 sets on an enabled upper-group pin change.
// - flag bit 6 sets on an enabled lower-group pin change.
// - flag bit 0 sets on an edge or change of the dedicated pin.
// - set flag with its enable and global bit requests its vector.
// - a flag clears when the cpu takes its vector.
// - writing one clears a flag; writing zero leaves it.
// - dedicated flag is held clear while in low-level mode.
// - upper mask bits enable single pins only with upper group enable.
// - lower mask bits enable single pins only with lower group enable.
// - change and low-level wake terms use the raw pins; the wake output is registered.
// - edge detection needs the clock and stops when it halts.
`timescale 1ns/10ps
`default_nettype none
module epiu_top
   import epiu_pkg::*;
#(
   parameter int GRP_W = 8
) (
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic [2:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata,
   input  wire logic              global_ie,
   input  wire logic              dedicated_irq_pin,
   input  wire logic [GRP_W-1:0]  upper_change_pins,
   input  wire logic [GRP_W-1:0]  lower_change_pins,
   input  wire epiu_pkg::epiu_vec_t vec_ack,
   output epiu_pkg::epiu_vec_t    irq_req,
   output logic                   wake_req
);
   import epiu_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state
   logic [1:0]       sense_ff,   nxt_sense;
   logic [7:0]       enable_ff,  nxt_enable;
   epiu_vec_t        flags_ff,   nxt_flags;
   logic [GRP_W-1:0] mask_hi_ff, nxt_mask_hi;
   logic [GRP_W-1:0] mask_lo_ff, nxt_mask_lo;
   logic             ded_s_ff,   nxt_ded_s;
   logic             ded_p_ff,   nxt_ded_p;
   logic [GRP_W-1:0] hi_s_ff,    nxt_hi_s;
   logic [GRP_W-1:0] hi_p_ff,    nxt_hi_p;
   logic [GRP_W-1:0] lo_s_ff,    nxt_lo_s;
   logic [GRP_W-1:0] lo_p_ff,    nxt_lo_p;
   logic [7:0]       rdata_ff,   nxt_rdata;
   epiu_vec_t        req_ff,     nxt_req;
   logic             wake_ff,    nxt_wake;

   logic      ded_edge;
   logic      ded_low;
   logic      hi_chg;
   logic      lo_chg;
   logic      hi_wake;
   logic      lo_wake;
   epiu_vec_t w1c;

   ////////////////////////////////////////////////////////////////////////
   // pin sampling: inputs are synchronous, one register stage then history
   // sample before edge
   always_comb begin
      nxt_ded_s = dedicated_irq_pin;
      nxt_ded_p = ded_s_ff;
      nxt_hi_s  = upper_change_pins;
      nxt_hi_p  = hi_s_ff;
      nxt_lo_s  = lower_change_pins;
      nxt_lo_p  = lo_s_ff;
   end

   always_comb begin
      ded_low = (sense_ff == SENSE_LOW) && !ded_s_ff;
      unique case (sense_ff)
         SENSE_ANY:  ded_edge = ded_s_ff ^ ded_p_ff;
         SENSE_FALL: ded_edge = ded_p_ff & ~ded_s_ff;
         SENSE_RISE: ded_edge = ~ded_p_ff & ded_s_ff;
         default:    ded_edge = 1'b0;
      endcase
   end

   // per-pin mask gated by group enable
   // and the same for the lower group
   // compare with last value, or per group
   assign hi_chg = enable_ff[BIT_HI] & |((hi_s_ff ^ hi_p_ff) & mask_hi_ff);
   assign lo_chg = enable_ff[BIT_LO] & |((lo_s_ff ^ lo_p_ff) & mask_lo_ff);

   // clockless wake terms: raw pin against last sampled value
   assign hi_wake = enable_ff[BIT_HI]
                  & |((upper_change_pins ^ hi_s_ff) & mask_hi_ff);
   assign lo_wake = enable_ff[BIT_LO]
                  & |((lower_change_pins ^ lo_s_ff) & mask_lo_ff);

   ////////////////////////////////////////////////////////////////////////
   // register writes and flags
   always_comb begin
      w1c         = '0;
      nxt_sense   = sense_ff;
      nxt_enable  = enable_ff;
      nxt_mask_hi = mask_hi_ff;
      nxt_mask_lo = mask_lo_ff;
      if (reg_wr) begin
         unique case (reg_addr)
            REG_SENSE:   nxt_sense   = reg_wdata[1:0];
            REG_ENABLE:  nxt_enable  = reg_wdata & 8'hc1;
            REG_FLAGS:   w1c = '{hi:  reg_wdata[BIT_HI],
                                 lo:  reg_wdata[BIT_LO],
                                 ded: reg_wdata[BIT_DED]};
            REG_MASK_LO: nxt_mask_lo = reg_wdata[GRP_W-1:0];
            REG_MASK_HI: nxt_mask_hi = reg_wdata[GRP_W-1:0];
            default: ;
         endcase
      end
      nxt_flags = flags_ff & ~w1c & ~vec_ack;
      // upper flag set wins over clear
      if (hi_chg) nxt_flags.hi = 1'b1;
      // lower flag set wins over clear
      if (lo_chg) nxt_flags.lo = 1'b1;
      if (ded_edge) nxt_flags.ded = 1'b1;
      if (sense_ff == SENSE_LOW) nxt_flags.ded = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // requests, wake and read data
   always_comb begin
      // enable bit 0, pin direction ignored
      nxt_req.ded = global_ie & enable_ff[BIT_DED]
                  & (flags_ff.ded | ded_low);
      nxt_req.hi  = global_ie & enable_ff[BIT_HI] & flags_ff.hi;
      nxt_req.lo  = global_ie & enable_ff[BIT_LO] & flags_ff.lo;
      // wake needs no edge; low level also wakes
      nxt_wake    = hi_wake | lo_wake
                  | (enable_ff[BIT_DED] & (sense_ff == SENSE_LOW)
                     & !dedicated_irq_pin);
      nxt_rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            REG_SENSE:   nxt_rdata = {6'h00, sense_ff};
            REG_ENABLE:  nxt_rdata = enable_ff;
            REG_FLAGS:   nxt_rdata = {flags_ff.hi, flags_ff.lo, 5'h00,
                                      flags_ff.ded};
            REG_MASK_LO: nxt_rdata = mask_lo_ff;
            REG_MASK_HI: nxt_rdata = mask_hi_ff;
            default:     nxt_rdata = 8'h00;  // unmapped reads as zero
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sense_ff   <= 2'h0;
         enable_ff  <= RST_BYTE;
         flags_ff   <= '0;
         mask_hi_ff <= '0;
         mask_lo_ff <= '0;
         ded_s_ff   <= 1'b1;
         ded_p_ff   <= 1'b1;
         hi_s_ff    <= '0;
         hi_p_ff    <= '0;
         lo_s_ff    <= '0;
         lo_p_ff    <= '0;
         rdata_ff   <= RST_BYTE;
         req_ff     <= '0;
         wake_ff    <= 1'b0;
      end else begin
         sense_ff   <= nxt_sense;
         enable_ff  <= nxt_enable;
         flags_ff   <= nxt_flags;
         mask_hi_ff <= nxt_mask_hi;
         mask_lo_ff <= nxt_mask_lo;
         ded_s_ff   <= nxt_ded_s;
         ded_p_ff   <= nxt_ded_p;
         hi_s_ff    <= nxt_hi_s;
         hi_p_ff    <= nxt_hi_p;
         lo_s_ff    <= nxt_lo_s;
         lo_p_ff    <= nxt_lo_p;
         rdata_ff   <= nxt_rdata;
         req_ff     <= nxt_req;
         wake_ff    <= nxt_wake;
      end
   end

   assign reg_rdata = rdata_ff;
   assign irq_req   = req_ff;
   assign wake_req  = wake_ff;

   ////////////////////////////////////////////////////////////////////////
   // checks
   rise_sets_flag_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (sense_ff == SENSE_RISE && ded_s_ff && !ded_p_ff) |=> flags_ff.ded)
      else $error("rising edge did not set dedicated flag");

   pulse_caught_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (sense_ff == SENSE_ANY && $stable(sense_ff)
       && dedicated_irq_pin != $past(dedicated_irq_pin)) |-> ##2 flags_ff.ded)
      else $error("pin change not flagged within two cycles");

   ded_req_gate_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      irq_req.ded |-> $past(global_ie) && $past(enable_ff[BIT_DED]))
      else $error("dedicated request without enables");

   hi_req_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (global_ie && enable_ff[BIT_HI] && flags_ff.hi) |=> irq_req.hi)
      else $error("upper request missing");

   lo_req_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      irq_req.lo |-> $past(flags_ff.lo) && $past(enable_ff[BIT_LO]))
      else $error("lower request without flag");

   ack_clears_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (vec_ack.hi && !hi_chg) |=> !flags_ff.hi)
      else $error("taken vector did not clear upper flag");

   w1c_flag_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (reg_wr && reg_addr == REG_FLAGS && !reg_wdata[BIT_LO] && flags_ff.lo)
      |=> flags_ff.lo)
      else $error("writing zero cleared lower flag");

   level_no_flag_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (sense_ff == SENSE_LOW) |=> !flags_ff.ded)
      else $error("dedicated flag set in level mode");

   mask_gates_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (!enable_ff[BIT_HI] && !flags_ff.hi && !vec_ack.hi
       && !(reg_wr && reg_addr == REG_ENABLE)) |=> !flags_ff.hi)
      else $error("upper flag set while group disabled");

   ////////////////////////////////////////////////////////////////////////
   // flag setting, clearing and output checks
   fall_sets_flag_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (sense_ff == SENSE_FALL && !ded_s_ff && ded_p_ff) |=> flags_ff.ded)
      else $error("falling edge did not set dedicated flag");

   hi_flag_set_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (enable_ff[BIT_HI] && |((hi_s_ff ^ hi_p_ff) & mask_hi_ff))
      |=> flags_ff.hi)
      else $error("enabled upper pin change did not set flag");

   lo_flag_set_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (enable_ff[BIT_LO] && |((lo_s_ff ^ lo_p_ff) & mask_lo_ff))
      |=> flags_ff.lo)
      else $error("enabled lower pin change did not set flag");

   ded_req_level_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (global_ie && enable_ff[BIT_DED] && flags_ff.ded) |=> irq_req.ded)
      else $error("dedicated request missing");

   lo_ack_clear_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (vec_ack.lo && !lo_chg) |=> !flags_ff.lo)
      else $error("taken vector did not clear lower flag");

   ded_ack_clear_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (vec_ack.ded && !ded_edge) |=> !flags_ff.ded)
      else $error("taken vector did not clear dedicated flag");

   w1c_ded_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (reg_wr && reg_addr == REG_FLAGS && reg_wdata[BIT_DED] && !ded_edge)
      |=> !flags_ff.ded)
      else $error("writing one did not clear dedicated flag");

   lo_mask_gate_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (!enable_ff[BIT_LO] && !flags_ff.lo && !vec_ack.lo
       && !(reg_wr && reg_addr == REG_ENABLE)) |=> !flags_ff.lo)
      else $error("lower flag set while group disabled");

   wake_low_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (enable_ff[BIT_DED] && sense_ff == SENSE_LOW && !dedicated_irq_pin)
      |=> wake_req)
      else $error("low level did not raise wake");

   // no disable here: this one watches the reset itself
   reset_clears_a: assert property (
      @(posedge clk_sys)
      sys_rst |=> (irq_req == 3'h0 && reg_rdata == 8'h00 && !wake_req))
      else $error("outputs not cleared by reset");

endmodule
`default_nettype wire

/* File: verif/epiu_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
// cpu side: takes every pending vector ack_dly plus one cycles after it shows
module epiu_cpu_model (
   input  wire logic                clk_sys,
   input  wire logic                sys_rst,
   input  wire epiu_pkg::epiu_vec_t irq_req,
   input  wire logic [3:0]          ack_dly,
   output epiu_pkg::epiu_vec_t      vec_ack
);
   import epiu_pkg::*;
   logic [3:0] wait_ff;
   ////////////////////////////////////////////////////////////////////////
   // take pulse lasts one cycle; ack_dly of zero never takes
   always_ff @(posedge clk_sys) begin
      vec_ack <= '0;
      if (sys_rst || irq_req == '0 || ack_dly == 4'h0) begin
         wait_ff <= 4'h0;
      end else if (wait_ff < ack_dly) begin
         wait_ff <= wait_ff + 4'h1;
      end else begin
         vec_ack <= irq_req;
         wait_ff <= 4'h0; // restart so a slow drop is not taken twice
      end
   end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
   import epiu_pkg::*;
   logic       clk_sys, sys_rst, reg_wr, reg_rd, global_ie, ded_pin, wake_req;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, up_pins, lo_pins;
   logic [3:0] ack_dly;
   epiu_vec_t  vec_ack, irq_req;
   int         fails, cmp_count;
   ////////////////////////////////////////////////////////////////////////
   epiu_top dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .global_ie(global_ie),
      .dedicated_irq_pin(ded_pin), .upper_change_pins(up_pins),
      .lower_change_pins(lo_pins), .vec_ack(vec_ack), .irq_req(irq_req),
      .wake_req(wake_req));
   epiu_cpu_model cpu_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .irq_req(irq_req), .ack_dly(ack_dly), .vec_ack(vec_ack));
   ////////////////////////////////////////////////////////////////////////
   // bus cycles and comparisons
   task idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // read data stand one cycle after the strobe; return on a clock edge
   task rdchk(input logic [2:0] a, input logic [7:0] e, input string nm);
      @(posedge clk_sys);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(nm, e, reg_rdata);
      @(posedge clk_sys);
   endtask
   // bounded wait for a request pattern, looked at off the edge
   task wait_req(input logic [2:0] e, input int n);
      #1;
      for (int i = 0; i < n && irq_req !== e; i++) begin
         @(posedge clk_sys);
         #1;
      end
      chk("irq_req", {5'h0, e}, {5'h0, irq_req});
      @(posedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      for (int a = 0; a < 8; a++) rdchk(3'(a), RST_BYTE, "reset");
      wr(REG_MASK_HI, 8'ha5); wr(REG_MASK_LO, 8'h5a); wr(3'h5, 8'hff);
      wr(REG_ENABLE, 8'hff);
      rdchk(REG_MASK_HI, 8'ha5, "mask hi");
      rdchk(REG_MASK_LO, 8'h5a, "mask lo");
      rdchk(3'h5, 8'h00, "unmapped");
      rdchk(REG_ENABLE, 8'hc1, "enable");
      wr(REG_ENABLE, 8'h00); wr(REG_MASK_HI, 8'h00); wr(REG_MASK_LO, 8'h00);
      $display("test reset done");
   endtask
   // every edge mode, both pin edges, write-zero and write-one on the flag
   task t_sense;
      for (int m = 1; m < 4; m++) begin
         wr(REG_SENSE, 8'(m)); wr(REG_FLAGS, 8'hff);
         ded_pin <= 1'b0; idle(3);
         rdchk(REG_FLAGS, {7'h0, m != 3}, "fall flag");
         wr(REG_FLAGS, 8'hfe);
         rdchk(REG_FLAGS, {7'h0, m != 3}, "kept flag");
         wr(REG_FLAGS, 8'h01);
         rdchk(REG_FLAGS, 8'h00, "cleared flag");
         ded_pin <= 1'b1; idle(3);
         rdchk(REG_FLAGS, {7'h0, m != 2}, "rise flag");
      end
      $display("test sense done");
   endtask
   // request gated by the global bit, then taken by the cpu
   task t_req;
      wr(REG_SENSE, {6'h0, SENSE_RISE}); wr(REG_FLAGS, 8'hff);
      wr(REG_ENABLE, 8'h01); ack_dly <= 4'h2;
      ded_pin <= 1'b0; idle(2); ded_pin <= 1'b1; idle(4);
      wait_req(3'b000, 1);
      global_ie <= 1'b1;
      wait_req(3'b001, 4);
      wait_req(3'b000, 12);
      rdchk(REG_FLAGS, 8'h00, "taken flag");
      $display("test request done");
   endtask
   // low level asks straight from the pin; driver holds it low long
   task t_low;
      ack_dly <= 4'h0; wr(REG_SENSE, {6'h0, SENSE_LOW});
      ded_pin <= 1'b0; idle(4);
      wait_req(3'b001, 1);
      #1 chk("wake", 8'h01, {7'h0, wake_req});
      rdchk(REG_FLAGS, 8'h00, "level flag");
      global_ie <= 1'b0; idle(2);
      wait_req(3'b000, 1);
      ded_pin <= 1'b1; global_ie <= 1'b1; idle(4);
      #1 chk("wake", 8'h00, {7'h0, wake_req});
      wait_req(3'b000, 1);
      wr(REG_SENSE, {6'h0, SENSE_RISE});
      $display("test level done");
   endtask
   // masked and unmasked pins in both groups, upper group enable off and on
   task t_groups;
      wr(REG_ENABLE, 8'hc0); wr(REG_MASK_HI, 8'h80); wr(REG_MASK_LO, 8'h01);
      wr(REG_FLAGS, 8'hff);
      up_pins <= 8'h40; lo_pins <= 8'h02; idle(4);
      rdchk(REG_FLAGS, 8'h00, "masked pins");
      up_pins <= 8'hc0; idle(1);
      #1 chk("wake", 8'h01, {7'h0, wake_req});
      idle(3);
      rdchk(REG_FLAGS, 8'h80, "upper flag");
      wait_req(3'b100, 2);
      lo_pins <= 8'h03; idle(4);
      rdchk(REG_FLAGS, 8'hc0, "lower flag");
      wait_req(3'b110, 2);
      wr(REG_FLAGS, 8'h80);
      rdchk(REG_FLAGS, 8'h40, "lower kept");
      wr(REG_FLAGS, 8'hc0); wr(REG_ENABLE, 8'h00);
      up_pins <= 8'h40; idle(4);
      rdchk(REG_FLAGS, 8'h00, "group off");
      wr(REG_ENABLE, 8'hc0); ack_dly <= 4'h3;
      up_pins <= 8'hc0; lo_pins <= 8'h02; idle(3);
      wait_req(3'b110, 2);
      wait_req(3'b000, 12);
      rdchk(REG_FLAGS, 8'h00, "group taken");
      $display("test groups done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // clock at 200 MHz
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // watchdog well past the few hundred cycles the tests take
   initial begin
      #100000;
      fails++;
      give_verdict;
   end
   // main sequence
   initial begin
      sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 3'h0;
      reg_wdata = 8'h00; global_ie = 1'b0; ded_pin = 1'b1;
      up_pins = 8'h00; lo_pins = 8'h00; ack_dly = 4'h0;
      fails = 0; cmp_count = 0;
      idle(2);
      sys_rst <= 1'b0;
      t_reset; t_sense; t_req; t_low; t_groups;
      give_verdict;
   end
endmodule
`default_nettype wire
